//--- common/crtc_pkg.sv
package crtc_pkg;

    // register byte offsets
    localparam logic [7:0] CRTC_STATUS_OFF  = 8'h00;
    localparam logic [7:0] CRTC_CONTROL_OFF = 8'h04;
    localparam logic [7:0] CRTC_DATA_OFF    = 8'h08;
    localparam logic [7:0] CRTC_COUNT_OFF   = 8'h0c;

    // bus bit n maps to data bit 35-n
    localparam int CRTC_B_CARD_PRESENT = 11;
    localparam int CRTC_B_HOPPER_EMPTY = 10;
    localparam int CRTC_B_IN_PROGRESS  = 9;
    localparam int CRTC_B_READ_REQ     = 9;
    localparam int CRTC_B_TROUBLE      = 8;
    localparam int CRTC_B_OVERRUN      = 7;
    localparam int CRTC_B_READY        = 6;
    localparam int CRTC_B_FILE_END     = 5;
    localparam int CRTC_B_CARD_END     = 4;
    localparam int CRTC_B_COL_READY    = 3;
    localparam int CRTC_B_CHAN_LSB     = 0;
    localparam int CRTC_B_READY_EN     = 12;
    localparam int CRTC_B_TROUBLE_EN   = 13;

    localparam int CRTC_STATUS_W  = 18;
    localparam int CRTC_COLUMN_W  = 12;
    localparam int CRTC_CHAN_W    = 3;
    localparam int CRTC_COUNT_W   = 7;
    localparam int CRTC_COLUMNS   = 80;
    localparam int CRTC_SYNC_W    = 19;

    localparam logic [CRTC_CHAN_W-1:0] CRTC_CHAN_RESET = 3'h0;

    // timing
    localparam int CRTC_CLK_PS    = 5000;
    localparam int CRTC_PICK_PS   = 25000000;
    localparam int CRTC_PICK_CYC  =
        (CRTC_PICK_PS + CRTC_CLK_PS - 1) / CRTC_CLK_PS;

    typedef struct packed {
        logic                     power_ok;
        logic                     hopper_empty_in;
        logic                     card_present_in;
        logic                     reader_ready_in;
        logic                     trouble_in;
        logic                     end_of_file_in;
        logic                     column_strobe_in;
        logic [CRTC_COLUMN_W-1:0] column_in;
    } crtc_rdr_t;

    typedef struct packed {
        logic [31:0] paddr;
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] pwdata;
    } crtc_apb_req_t;

endpackage

//--- rtl/crtc_top.sv
module crtc_top
    import crtc_pkg::*;
#(
    parameter int PICK_CYCLES = CRTC_PICK_CYC
) (
    input  wire logic          MCLK,
    input  wire logic          NRST,
    input  wire crtc_apb_req_t APB_REQ,
    output logic               PREADY,
    output logic [31:0]        PRDATA,
    output logic               PSLVERR,
    input  wire crtc_rdr_t     READER,
    output logic               READ_COMMAND_OUT,
    output logic [7:1]         PI_REQ
);

    if (PICK_CYCLES < 1 || PICK_CYCLES > 65535) begin : g_chk
        $error("PICK_CYCLES out of range");
    end

    // input synchronisers
    logic [CRTC_SYNC_W-1:0] s1_q;
    logic [CRTC_SYNC_W-1:0] s2_q;
    logic [CRTC_SYNC_W-1:0] s3_q;
    logic [CRTC_SYNC_W-1:0] flt_q;
    logic [CRTC_SYNC_W-1:0] flt_d;
    crtc_rdr_t              rdr;
    logic                   strobe_prev_q;
    logic                   present_prev_q;

    // flags and state
    logic [CRTC_COLUMN_W-1:0] column_buffer_q;
    logic                     column_ready_flag_q;
    logic                     column_overrun_flag_q;
    logic                     card_end_flag_q;
    logic                     card_in_progress_flag_q;
    logic                     file_end_flag_q;
    logic                     read_request_flag_q;
    logic                     ready_irq_enable_q;
    logic                     trouble_irq_enable_q;
    logic [CRTC_CHAN_W-1:0]   channel_q;
    logic [CRTC_COUNT_W-1:0]  column_count_q;
    logic [15:0]              pick_cnt_q;
    logic                     pick_pulse_q;
    // bus side
    logic        pready_q;
    logic [31:0] prdata_q;
    logic        pslverr_q;
    logic [7:1]  pi_req_q;
    logic        read_cmd_q;
    logic        access;
    logic        done;
    logic        wr_done;
    logic        device_select;
    logic        column_read_strobe;
    logic        status_read_strobe;
    logic        ctrl_write;
    logic        column_load_pulse;
    logic        card_end_event;
    logic        card_start_event;
    logic        pick_start;
    logic        idle_ready_condition;
    logic        trouble_pi;
    logic        file_end_set;
    logic        pi_any;
    logic [CRTC_STATUS_W-1:0] status_word;
    function automatic logic is_off(input logic [31:0] a,
                                    input logic [7:0]  off);
        return a[7:0] == off;
    endfunction

    // three-flop synchroniser with agreement filter
    // synchronise reader inputs
    always_comb begin
        flt_d = flt_q;
        for (int i = 0; i < CRTC_SYNC_W; i++) begin
            if (s2_q[i] == s3_q[i]) begin
                flt_d[i] = s3_q[i];
            end
        end
    end

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            s1_q  <= '0;
            s2_q  <= '0;
            s3_q  <= '0;
            flt_q <= '0;
        end else begin
            s1_q  <= READER;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            flt_q <= flt_d;
        end
    end

    assign rdr = flt_q;
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            strobe_prev_q  <= 1'b0;
            present_prev_q <= 1'b0;
        end else begin
            strobe_prev_q  <= rdr.column_strobe_in;
            present_prev_q <= rdr.card_present_in;
        end
    end

    assign column_load_pulse = rdr.column_strobe_in & ~strobe_prev_q;
    assign card_end_event    = ~rdr.card_present_in & present_prev_q;
    assign card_start_event  = rdr.card_present_in & ~present_prev_q;

    // bus decode
    assign access  = APB_REQ.psel & APB_REQ.penable;
    assign done    = access & pready_q;
    assign wr_done = done & APB_REQ.pwrite;
    assign device_select = is_off(APB_REQ.paddr, CRTC_DATA_OFF);
    assign column_read_strobe = done & ~APB_REQ.pwrite & device_select
                              & rdr.power_ok;
    assign status_read_strobe =
        access & ~APB_REQ.pwrite & is_off(APB_REQ.paddr, CRTC_STATUS_OFF);
    assign ctrl_write = wr_done & is_off(APB_REQ.paddr, CRTC_CONTROL_OFF);

    always_comb begin
        status_word = '0;
        status_word[CRTC_B_CARD_PRESENT] = rdr.card_present_in;
        status_word[CRTC_B_HOPPER_EMPTY] = rdr.hopper_empty_in;
        status_word[CRTC_B_IN_PROGRESS]  = card_in_progress_flag_q;
        status_word[CRTC_B_TROUBLE]      = rdr.trouble_in;
        status_word[CRTC_B_OVERRUN]      = column_overrun_flag_q;
        status_word[CRTC_B_READY]        = rdr.reader_ready_in;
        status_word[CRTC_B_FILE_END]     = file_end_flag_q;
        status_word[CRTC_B_CARD_END]     = card_end_flag_q;
        status_word[CRTC_B_COL_READY]    = column_ready_flag_q;
        status_word[CRTC_B_CHAN_LSB +: CRTC_CHAN_W] = channel_q;
        status_word[CRTC_B_READY_EN]     = ready_irq_enable_q;
        status_word[CRTC_B_TROUBLE_EN]   = trouble_irq_enable_q;
    end

    // apb slave, one wait state
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            pready_q  <= 1'b0;
            prdata_q  <= '0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q  <= access & ~pready_q;
            pslverr_q <= 1'b0;
            prdata_q  <= '0;
            if (access & ~pready_q) begin
                if (status_read_strobe) begin
                    prdata_q <= {14'h0000, status_word};
                end else if (device_select & ~APB_REQ.pwrite) begin
                    prdata_q <= rdr.power_ok
                              ? {20'h00000, column_buffer_q} : '0;
                end else if (is_off(APB_REQ.paddr, CRTC_COUNT_OFF)
                             && !APB_REQ.pwrite) begin
                    prdata_q <= {25'h0000000, column_count_q};
                end else begin
                    pslverr_q <= ~is_off(APB_REQ.paddr, CRTC_CONTROL_OFF);
                end
            end
        end
    end

    // control register fields
    // channel cleared on reset
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            channel_q            <= CRTC_CHAN_RESET;
            ready_irq_enable_q   <= 1'b0;
            trouble_irq_enable_q <= 1'b0;
        end else if (ctrl_write) begin
            channel_q <= APB_REQ.pwdata[CRTC_B_CHAN_LSB +: CRTC_CHAN_W];
            ready_irq_enable_q   <= APB_REQ.pwdata[CRTC_B_READY_EN];
            trouble_irq_enable_q <= APB_REQ.pwdata[CRTC_B_TROUBLE_EN];
        end
    end

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            column_buffer_q <= '0;
        end else if (column_load_pulse) begin
            column_buffer_q <= rdr.column_in;
        end
    end

    // column data ready, set beats clear
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            column_ready_flag_q <= 1'b0;
        end else if (column_load_pulse) begin
            column_ready_flag_q <= 1'b1;
        end else if (column_read_strobe) begin
            column_ready_flag_q <= 1'b0;
        end
    end

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            column_overrun_flag_q <= 1'b0;
        end else if (column_load_pulse & column_ready_flag_q) begin
            column_overrun_flag_q <= 1'b1;
        end else if (ctrl_write & APB_REQ.pwdata[CRTC_B_OVERRUN]) begin
            column_overrun_flag_q <= 1'b0;
        end
    end

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            column_count_q <= '0;
        end else if (card_start_event) begin
            column_count_q <= '0;
        end else if (column_load_pulse
                     && column_count_q < CRTC_COUNT_W'(CRTC_COLUMNS)) begin
            column_count_q <= column_count_q + 1'b1;
        end
    end

    // card end and reading flags
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            card_end_flag_q <= 1'b0;
        end else if (card_end_event) begin
            card_end_flag_q <= 1'b1;
        end else if (ctrl_write & APB_REQ.pwdata[CRTC_B_CARD_END]) begin
            card_end_flag_q <= 1'b0;
        end
    end
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            card_in_progress_flag_q <= 1'b0;
        end else if (card_start_event) begin
            card_in_progress_flag_q <= 1'b1;
        end else if (card_end_event) begin
            card_in_progress_flag_q <= 1'b0;
        end
    end

    assign file_end_set = rdr.trouble_in & rdr.end_of_file_in;

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            file_end_flag_q <= 1'b0;
        end else if (file_end_set) begin
            file_end_flag_q <= 1'b1;
        end else if (ctrl_write & APB_REQ.pwdata[CRTC_B_FILE_END]) begin
            file_end_flag_q <= 1'b0;
        end
    end

    // pick control
    // ready and request start pick
    assign pick_start = rdr.reader_ready_in & read_request_flag_q
                      & ~pick_pulse_q;

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            read_request_flag_q <= 1'b0;
        end else if (ctrl_write & APB_REQ.pwdata[CRTC_B_READ_REQ]) begin
            read_request_flag_q <= 1'b1;
        end else if (pick_start) begin
            read_request_flag_q <= 1'b0;
        end
    end

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            pick_pulse_q <= 1'b0;
            pick_cnt_q   <= '0;
        end else if (pick_start) begin
            pick_pulse_q <= 1'b1;
            pick_cnt_q   <= 16'(PICK_CYCLES - 1);
        end else if (pick_pulse_q) begin
            if (pick_cnt_q == 16'h0000) begin
                pick_pulse_q <= 1'b0;
            end else begin
                pick_cnt_q <= pick_cnt_q - 1'b1;
            end
        end
    end

    assign idle_ready_condition = rdr.reader_ready_in
                                & ~read_request_flag_q & ~pick_pulse_q;
    assign trouble_pi = rdr.trouble_in & trouble_irq_enable_q;
    assign pi_any = column_ready_flag_q | column_overrun_flag_q
                  | card_end_flag_q | file_end_flag_q | trouble_pi
                  | (idle_ready_condition & ready_irq_enable_q);

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            pi_req_q <= '0;
        end else begin
            for (int c = 1; c < 8; c++) begin
                pi_req_q[c] <= pi_any && (channel_q == CRTC_CHAN_W'(c));
            end
        end
    end

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            read_cmd_q <= 1'b0;
        end else begin
            read_cmd_q <= pick_start | (pick_pulse_q & (pick_cnt_q != '0));
        end
    end
    assign PREADY           = pready_q;
    assign PRDATA           = prdata_q;
    assign PSLVERR          = pslverr_q;
    assign PI_REQ           = pi_req_q;
    assign READ_COMMAND_OUT = read_cmd_q;

endmodule

//--- test/crtc_top_props.sv
module crtc_top_props
    import crtc_pkg::*;
#(
    parameter int PICK_CYCLES = CRTC_PICK_CYC
) (
    input wire logic          MCLK,
    input wire logic          NRST,
    input wire crtc_apb_req_t APB_REQ,
    input wire logic          PREADY,
    input wire logic [31:0]   PRDATA,
    input wire logic          PSLVERR,
    input wire crtc_rdr_t     READER,
    input wire logic          READ_COMMAND_OUT,
    input wire logic [7:1]    PI_REQ
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [16:0] pick_cnt_q;

    // pulse length counter
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            pick_cnt_q <= '0;
        end else if (READ_COMMAND_OUT) begin
            pick_cnt_q <= pick_cnt_q + 17'h1;
        end else begin
            pick_cnt_q <= '0;
        end
    end

    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!NRST);

    sequence s_acc;
        APB_REQ.psel && APB_REQ.penable && !PREADY;
    endsequence
    sequence s_adr(logic [7:0] a, logic w);
        s_acc ##0 (APB_REQ.paddr[7:0] == a && APB_REQ.pwrite == w);
    endsequence

    chk_answer_next: assert property (s_acc |=> PREADY)
        else $error("no answer after access");
    chk_ready_once: assert property (PREADY |=> !PREADY)
        else $error("ready held too long");
    chk_err_qual: assert property (PSLVERR |-> PREADY)
        else $error("error without ready");
    chk_rdata_idle: assert property (!PREADY |-> PRDATA == 32'h0)
        else $error("read data outside answer");
    chk_unmapped_err: assert property (s_adr(8'h10, 1'b0) |=> PSLVERR)
        else $error("unmapped read accepted");
    chk_status_ro: assert property (s_adr(8'h00, 1'b1) |=> PSLVERR)
        else $error("status write accepted");
    chk_ctl_read: assert property (s_adr(8'h04, 1'b0) |=>
        PRDATA == 32'h0 && !PSLVERR)
        else $error("control read not zero");
    chk_pi_onehot: assert property ($onehot0(PI_REQ))
        else $error("several request lines");
    chk_pick_len: assert property ($fell(READ_COMMAND_OUT) |->
        pick_cnt_q == PICK_CYCLES)
        else $error("pick pulse short");
    chk_pick_max: assert property (READ_COMMAND_OUT |->
        pick_cnt_q < PICK_CYCLES)
        else $error("pick pulse long");
endmodule

bind crtc_top crtc_top_props #(.PICK_CYCLES(PICK_CYCLES)) props_i (
    .MCLK            (MCLK),
    .NRST            (NRST),
    .APB_REQ         (APB_REQ),
    .PREADY          (PREADY),
    .PRDATA          (PRDATA),
    .PSLVERR         (PSLVERR),
    .READER          (READER),
    .READ_COMMAND_OUT(READ_COMMAND_OUT),
    .PI_REQ          (PI_REQ)
);

//--- test/crtc_bus_model.sv
module crtc_bus_model
    import crtc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        pready,
    input  wire logic [31:0] prdata,
    input  wire logic        pslverr,
    output crtc_apb_req_t    req
);
    timeunit 1ns;
    timeprecision 100ps;

    initial req = '0;

    task automatic xfer(input logic [7:0] a, input logic w,
                        input logic [31:0] wd, output logic [31:0] rd,
                        output logic err);
        @(posedge clk);
        req.paddr <= {24'h0, a};
        req.pwrite <= w;
        req.pwdata <= wd;
        req.psel <= 1'b1;
        req.penable <= 1'b0;
        @(posedge clk);
        req.penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask
endmodule

//--- test/tb.sv
module tb
    import crtc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int          PICK = 20;
    localparam logic [31:0] CW   = 32'h00003005;
    localparam logic [6:0]  PI5  = 7'h10;

    logic          mclk = 1'b0;
    logic          nrst = 1'b0;
    crtc_apb_req_t apb;
    crtc_rdr_t     rdr;
    logic          pready;
    logic          pslverr;
    logic          rcmd;
    logic          err;
    logic [31:0]   prdata;
    logic [31:0]   rd;
    logic [7:1]    pi;
    int            num_errors = 0;
    int            n_compared = 0;
    int            pick_len = 0;

    always #2.5 mclk = ~mclk;

    always @(negedge mclk) begin
        if (rcmd === 1'b1) begin
            pick_len++;
        end
    end

    crtc_top #(.PICK_CYCLES(PICK)) crtc_top_i (
        .MCLK(mclk), .NRST(nrst), .APB_REQ(apb), .PREADY(pready),
        .PRDATA(prdata), .PSLVERR(pslverr), .READER(rdr),
        .READ_COMMAND_OUT(rcmd), .PI_REQ(pi)
    );

    crtc_bus_model crtc_bus_model_i (
        .clk(mclk), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .req(apb)
    );

    function automatic logic [31:0] m(input int i);
        return 32'h1 << i;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic settle;
        repeat (8) @(posedge mclk);
    endtask

    task automatic rdreg(input logic [7:0] a);
        crtc_bus_model_i.xfer(a, 1'b0, 32'h0, rd, err);
    endtask

    task automatic wr_ctl(input logic [31:0] d);
        crtc_bus_model_i.xfer(CRTC_CONTROL_OFF, 1'b1, d, rd, err);
    endtask

    task automatic st(input logic [31:0] s, input logic [6:0] p);
        rdreg(CRTC_STATUS_OFF);
        chk(rd, s);
        @(negedge mclk);
        chk({25'h0, pi}, {25'h0, p});
        @(posedge mclk);
    endtask

    task automatic strobe(input logic [11:0] c);
        rdr.column_in <= c;
        settle;
        rdr.column_strobe_in <= 1'b1;
        settle;
        rdr.column_strobe_in <= 1'b0;
        settle;
    endtask

    task automatic t_reset;
        st(32'h0, 7'h0);
        rdreg(8'h10);
        chk({31'h0, err}, 32'h1);
        crtc_bus_model_i.xfer(CRTC_STATUS_OFF, 1'b1, CW, rd, err);
        chk({31'h0, err}, 32'h1);
        rdreg(CRTC_CONTROL_OFF);
        chk({31'h0, err} | rd, 32'h0);
        crtc_bus_model_i.xfer(CRTC_COUNT_OFF, 1'b1, CW, rd, err);
        chk({31'h0, err}, 32'h1);
        wr_ctl(CW);
    endtask

    task automatic t_card_start;
        rdr.card_present_in <= 1'b1;
        settle;
        st(CW | m(CRTC_B_CARD_PRESENT) | m(CRTC_B_IN_PROGRESS), 7'h0);
    endtask

    task automatic t_column;
        logic [31:0] s;
        s = CW | m(CRTC_B_CARD_PRESENT) | m(CRTC_B_IN_PROGRESS);
        strobe(12'ha5c);
        st(s | m(CRTC_B_COL_READY), PI5);
        rdr.power_ok <= 1'b0;
        settle;
        rdreg(CRTC_DATA_OFF);
        chk(rd, 32'h0);
        rdr.power_ok <= 1'b1;
        settle;
        st(s | m(CRTC_B_COL_READY), PI5);
        rdreg(CRTC_DATA_OFF);
        chk(rd, 32'ha5c);
        st(s, 7'h0);
        strobe(12'h3ff);
        strobe(12'h801);
        st(s | m(CRTC_B_COL_READY) | m(CRTC_B_OVERRUN), PI5);
        wr_ctl(CW | m(CRTC_B_OVERRUN));
        rdreg(CRTC_DATA_OFF);
        chk(rd, 32'h801);
        st(s, 7'h0);
        rdreg(CRTC_COUNT_OFF);
        chk(rd, 32'h3);
        repeat (78) strobe(12'h001);
        rdreg(CRTC_COUNT_OFF);
        chk(rd, 32'h50);
        wr_ctl(CW | m(CRTC_B_OVERRUN));
        rdreg(CRTC_DATA_OFF);
        chk(rd, 32'h1);
        st(s, 7'h0);
    endtask

    task automatic t_card_end;
        rdr.card_present_in <= 1'b0;
        settle;
        st(CW | m(CRTC_B_CARD_END), PI5);
        wr_ctl(CW | m(CRTC_B_CARD_END));
        st(CW, 7'h0);
    endtask

    task automatic t_pick;
        rdr.reader_ready_in <= 1'b1;
        settle;
        st(CW | m(CRTC_B_READY), PI5);
        chk(32'(pick_len), 32'h0);
        wr_ctl(CW | m(CRTC_B_READ_REQ));
        repeat (2) @(negedge mclk);
        chk({25'h0, pi}, 32'h0);
        chk({31'h0, rcmd}, 32'h1);
        repeat (PICK + 10) @(posedge mclk);
        chk(32'(pick_len), 32'(PICK));
        rdr.reader_ready_in <= 1'b0;
        settle;
    endtask

    task automatic t_trouble;
        logic [31:0] s;
        s = CW | m(CRTC_B_TROUBLE);
        rdr.trouble_in <= 1'b1;
        settle;
        st(s, PI5);
        s = s | m(CRTC_B_HOPPER_EMPTY);
        rdr.hopper_empty_in <= 1'b1;
        rdr.end_of_file_in <= 1'b1;
        settle;
        st(s | m(CRTC_B_FILE_END), PI5);
        wr_ctl(CW & ~m(CRTC_B_TROUBLE_EN));
        st((s | m(CRTC_B_FILE_END)) & ~m(CRTC_B_TROUBLE_EN), PI5);
        rdr.end_of_file_in <= 1'b0;
        settle;
        wr_ctl(CW | m(CRTC_B_FILE_END));
        st(s, PI5);
        rdr.trouble_in <= 1'b0;
        settle;
        st(CW | m(CRTC_B_HOPPER_EMPTY), 7'h0);
    endtask

    task automatic t_mid_reset;
        strobe(12'h0f0);
        nrst <= 1'b0;
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
        settle;
        st(m(CRTC_B_HOPPER_EMPTY), 7'h0);
        rdreg(CRTC_DATA_OFF);
        chk(rd, 32'h0);
    endtask

    task automatic final_report;
        $display("compared %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        rdr = '0;
        rdr.power_ok = 1'b1;
        repeat (20) @(posedge mclk);
        nrst <= 1'b1;
        t_reset;
        t_card_start;
        t_column;
        t_card_end;
        t_pick;
        t_trouble;
        t_mid_reset;
        final_report;
    end

    initial begin
        #100000;
        num_errors++;
        final_report;
    end
endmodule
